// ==== core/dlr_pkg.sv ====
// Package for the dataline readout two-wire slave port.
// Assumes a single 200 MHz system clock; bus pins are sampled synchronously.
package dlr_pkg;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h10;
    localparam logic [6:0] ADDR_SEL_LOW  = 7'h11;
    localparam logic [2:0] NUM_BYTES     = 3'h5;
    localparam logic [7:0] FILL_BYTE     = 8'hff;
    localparam logic [7:0] SHIFT_RESET   = 8'hff;
    localparam int         BUF_DEPTH     = 2;

    typedef struct packed {
        logic       sda_out;
        logic       sda_oe;
    } dlr_pin_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_TX,
        ST_RX_ACK,
        ST_WAIT_STOP
    } dlr_state_e;
endpackage : dlr_pkg

// ==== core/dlr_i2c_slave.sv ====
// Read-only two-wire slave that returns five stored dataline bytes.
// Assumes scl and sda are already synchronised; the open-drain wire is resolved outside.
`timescale 1ns/1ps

// What this block does
// - Answer address byte 0010 0001 when select pin high, 0010 0011 when low.
// - Act only as slave transmitter; respond only to read-addressed transfers.
// - Acknowledge matching address; master acknowledges bytes it wants continued.
// - Supply stored information as five data bytes after the acknowledged address.
// - Shift every data byte out most significant bit first.
// - Unlimited reads; bytes after the fifth return FF until the transfer ends.
module dlr_i2c_slave
    import dlr_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    // Decoded data from the line decoder
    input  wire logic [39:0] line_data,
    input  wire logic        line_valid,
    output logic             line_ready,
    // Address select strap
    input  wire logic        addr_sel,
    // Two-wire bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Status
    output logic             busy
);
    dlr_state_e  state_reg;
    logic        scl_d_reg;
    logic        sda_d_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bit_cnt_reg;
    logic [2:0]  byte_cnt_reg;
    logic [39:0] hold_reg;
    logic        hold_ok_reg;
    logic [39:0] buf_mem [BUF_DEPTH];
    logic        wr_ptr_reg;
    logic        rd_ptr_reg;
    logic [1:0]  count_reg;
    dlr_pin_s    pin_reg;
    // Marks that eight address bits are in.
    // Without it, the scl fall that follows a start would be taken as the end of the address byte.
    logic        addr_full_reg;
    logic [7:0]  first_byte;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic buf_out_valid;
    logic buf_out_ready;
    logic in_xfer;

    assign scl_rise   = scl_in && !scl_d_reg;
    assign scl_fall   = !scl_in && scl_d_reg;
    assign start_cond = scl_in && scl_d_reg && sda_d_reg && !sda_in;
    assign stop_cond  = scl_in && scl_d_reg && !sda_d_reg && sda_in;
    assign in_xfer    = (state_reg != ST_IDLE);
    assign busy       = in_xfer;

    // Picks the byte for a given index; the buffer order is fixed by the decoder.
    function automatic logic [7:0] pick_byte(input logic [39:0] d, input logic [2:0] idx);
        logic [7:0] b;
        b = FILL_BYTE;
        case (idx)
            3'h0: b = d[39:32];
            3'h1: b = d[31:24];
            3'h2: b = d[23:16];
            3'h3: b = d[15:8];
            3'h4: b = d[7:0];
            default: b = FILL_BYTE;
        endcase
        return b;
    endfunction : pick_byte

    // Two-entry buffer so a dataline arriving during a read is not lost.
    assign line_ready    = (count_reg != 2'h2);
    assign buf_out_valid = (count_reg != 2'h0);
    // New data is only taken between transfers, which keeps a read coherent.
    assign buf_out_ready = !in_xfer;

    // First byte of a read, taken from the held line so the whole read stays coherent.
    assign first_byte = hold_ok_reg ? pick_byte(hold_reg, 3'h0) : FILL_BYTE;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else if (clk_en) begin
            if (line_valid && line_ready) begin
                wr_ptr_reg <= !wr_ptr_reg;
            end
            if (buf_out_valid && buf_out_ready) begin
                rd_ptr_reg <= !rd_ptr_reg;
            end
            count_reg <= count_reg + 2'(line_valid && line_ready) - 2'(buf_out_valid && buf_out_ready);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && line_valid && line_ready) begin
            buf_mem[wr_ptr_reg] <= line_data;
        end
    end

    // Until a dataline has been decoded the port reads back as fill bytes.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_reg    <= 40'h0;
            hold_ok_reg <= 1'b0;
        end else if (clk_en && buf_out_valid && buf_out_ready) begin
            hold_reg    <= buf_mem[rd_ptr_reg];
            hold_ok_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else if (clk_en) begin
            scl_d_reg <= scl_in;
            sda_d_reg <= sda_in;
        end
    end

    // Bus protocol. Data changes on the falling clock edge, sampled on the rising.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= ST_IDLE;
            shift_reg    <= SHIFT_RESET;
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 3'h0;
            addr_full_reg <= 1'b0;
            pin_reg      <= '{sda_out: 1'b1, sda_oe: 1'b0};
        end else if (clk_en) begin
            if (start_cond) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 3'h0;
                addr_full_reg <= 1'b0;
                pin_reg     <= '{sda_out: 1'b1, sda_oe: 1'b0};
            end else if (stop_cond) begin
                state_reg <= ST_IDLE;
                pin_reg   <= '{sda_out: 1'b1, sda_oe: 1'b0};
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        pin_reg <= '{sda_out: 1'b1, sda_oe: 1'b0};
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_in};
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == 3'h7) begin
                                addr_full_reg <= 1'b1;
                            end
                        end else if (scl_fall && addr_full_reg && bit_cnt_reg == 3'h0) begin
                            // Only a read of our own address is acknowledged.
                            if (shift_reg[0] && shift_reg[7:1] == (addr_sel ? ADDR_SEL_HIGH : ADDR_SEL_LOW)) begin
                                pin_reg   <= '{sda_out: 1'b0, sda_oe: 1'b1};
                                state_reg <= ST_ADDR_ACK;
                            end else begin
                                state_reg <= ST_WAIT_STOP;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            // The acknowledge is released and the first data bit driven on the same fall.
                            shift_reg    <= first_byte;
                            pin_reg      <= '{sda_out: 1'b0, sda_oe: !first_byte[7]};
                            byte_cnt_reg <= 3'h1;
                            bit_cnt_reg  <= 3'h0;
                            state_reg    <= ST_TX;
                        end
                    end
                    ST_TX: begin
                        pin_reg.sda_out <= 1'b0;
                        pin_reg.sda_oe  <= !shift_reg[7];
                        if (scl_fall) begin
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            shift_reg   <= {shift_reg[6:0], 1'b1};
                            if (bit_cnt_reg == 3'h7) begin
                                state_reg <= ST_RX_ACK;
                            end
                        end
                    end
                    ST_RX_ACK: begin
                        pin_reg <= '{sda_out: 1'b1, sda_oe: 1'b0};
                        if (scl_rise) begin
                            if (sda_in) begin
                                state_reg <= ST_WAIT_STOP;
                            end else begin
                                shift_reg <= (hold_ok_reg && byte_cnt_reg < NUM_BYTES)
                                             ? pick_byte(hold_reg, byte_cnt_reg) : FILL_BYTE;
                                if (byte_cnt_reg < NUM_BYTES) begin
                                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                                end
                            end
                        end else if (scl_fall) begin
                            bit_cnt_reg <= 3'h0;
                            state_reg   <= ST_TX;
                        end
                    end
                    ST_WAIT_STOP: begin
                        pin_reg <= '{sda_out: 1'b1, sda_oe: 1'b0};
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign sda_out = pin_reg.sda_out;
    assign sda_oe  = pin_reg.sda_oe;
endmodule : dlr_i2c_slave

// ==== test/dlr_master_model.sv ====
// Two-wire bus master model: start, address, reads, acknowledge, stop.
// Assumes the bench resolves sda through a pull-up.
`timescale 1ns/1ps
module dlr_master_model (
    // Clock
    input  wire logic sys_clk,
    // Bus
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    localparam int Q = 8;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : w
    // Sda only moves while scl is low, so no false start or stop is made.
    task automatic bit_x(input logic b, output logic r);
        sda_rel = b;
        w(Q);
        scl = 1'b1;
        w(Q);
        r = sda;
        w(Q);
        scl = 1'b0;
        w(Q);
    endtask : bit_x
    task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q[8], output logic nak);
        logic r;
        sda_rel = 1'b0;
        w(Q);
        scl = 1'b0;
        w(Q);
        for (int i = 7; i >= 0; i--) bit_x(a[i], r);
        bit_x(1'b1, nak);
        for (int k = 0; k < n && !nak; k++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_x(1'b1, r);
                q[k][i] = r;
            end
            bit_x(k == n - 1, r);
        end
        sda_rel = 1'b0;
        w(Q);
        scl = 1'b1;
        w(Q);
        sda_rel = 1'b1;
        w(Q);
    endtask : rd
endmodule : dlr_master_model

// ==== test/dlr_i2c_slave_sva.sv ====
// Checker for the two-wire slave port.
// Assumes bus inputs already synchronous to sys_clk.
`timescale 1ns/1ps
module dlr_i2c_slave_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Watched ports
    input wire logic line_ready,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_quiet; !busy |-> !sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("sda driven while idle");
    property p_low; sda_oe |-> !sda_out; endproperty
    a_low: assert property (p_low) else $error("driven sda not low");
    property p_edge; $changed(sda_oe) |-> !scl_in; endproperty
    a_edge: assert property (p_edge) else $error("sda moved with scl high");
    property p_start; $rose(busy) |-> $past(scl_in) && !sda_in; endproperty
    a_start: assert property (p_start) else $error("busy without start");
    property p_stop; $fell(busy) |-> scl_in && sda_in; endproperty
    a_stop: assert property (p_stop) else $error("busy ended without stop");
    property p_hold; busy && !line_ready ##1 busy |-> !line_ready; endproperty
    a_hold: assert property (p_hold) else $error("buffer drained in transfer");
    c_ack: cover property ($rose(sda_oe));
    c_full: cover property (busy && !line_ready);
    c_stop: cover property ($fell(busy));
endmodule : dlr_i2c_slave_sva
bind dlr_i2c_slave dlr_i2c_slave_sva u_dlr_i2c_slave_sva(.sys_clk(sys_clk), .rstn(rstn), .line_ready(line_ready),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));

// ==== test/dlr_i2c_slave_tb.sv ====
// Self-checking bench for the two-wire slave port.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: %h", $time, g); end end
module dlr_i2c_slave_tb;
    import dlr_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [39:0] line_data = 40'h0;
    logic        line_valid = 1'b0;
    logic        addr_sel = 1'b1;
    logic        clk_en = 1'b1;
    logic        line_ready, scl, sda_rel, sda_out, sda_oe, busy, nak;
    wire         sda = sda_rel & ~(sda_oe & ~sda_out);
    int          n_fail = 0;
    int          total_checks = 0;
    logic [7:0]  q[8];
    initial forever #2.5 sys_clk = ~sys_clk;
    dlr_i2c_slave u_dlr_i2c_slave(.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .line_data(line_data),
        .line_valid(line_valid), .line_ready(line_ready), .addr_sel(addr_sel), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
    dlr_master_model u_dlr_master_model(.sys_clk(sys_clk), .scl(scl), .sda_rel(sda_rel), .sda(sda));
    task automatic push(input logic [39:0] d);
        line_data = d;
        line_valid = 1'b1;
        while (line_ready !== 1'b1) u_dlr_master_model.w(1);
        u_dlr_master_model.w(1);
        line_valid = 1'b0;
    endtask : push
    task automatic rdchk(input logic [7:0] a, input logic [39:0] d, input logic nx);
        u_dlr_master_model.rd(a, 7, q, nak);
        `CHK(nak, nx)
        for (int k = 0; k < 7 && !nx; k++) `CHK(q[k], k < 5 ? d[39-8*k -: 8] : FILL_BYTE)
    endtask : rdchk
    task automatic t_addr(input logic [39:0] d);
        logic [6:0] own, other;
        for (int s = 1; s >= 0; s--) begin
            addr_sel = s[0];
            own = s ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
            other = s ? ADDR_SEL_LOW : ADDR_SEL_HIGH;
            rdchk({own, 1'b1}, d, 1'b0);
            rdchk({other, 1'b1}, d, 1'b1);
            rdchk({own, 1'b0}, d, 1'b1);
        end
    endtask : t_addr
    // A frozen block neither answers the bus nor takes the offered line word.
    task automatic t_freeze(input logic [39:0] d);
        clk_en = 1'b0;
        line_data = d;
        line_valid = 1'b1;
        rdchk({ADDR_SEL_LOW, 1'b1}, d, 1'b1);
        `CHK(busy, 1'b0)
        clk_en = 1'b1;
        u_dlr_master_model.w(1);
        line_valid = 1'b0;
        u_dlr_master_model.w(5);
        rdchk({ADDR_SEL_LOW, 1'b1}, d, 1'b0);
    endtask : t_freeze
    task automatic t_hold(input logic [39:0] d);
        fork
            rdchk({ADDR_SEL_LOW, 1'b1}, d, 1'b0);
            begin
                while (busy !== 1'b1) u_dlr_master_model.w(1);
                push(40'h1122334455);
                u_dlr_master_model.w(1);
                push(40'hc3a55a3c99);
            end
        join
        u_dlr_master_model.w(10);
        rdchk({ADDR_SEL_LOW, 1'b1}, 40'hc3a55a3c99, 1'b0);
    endtask : t_hold
    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        conclude();
    end
    initial begin
        u_dlr_master_model.w(20);
        rstn = 1'b1;
        rdchk({ADDR_SEL_HIGH, 1'b1}, {5{FILL_BYTE}}, 1'b0);
        push(40'h80a5017ffe);
        u_dlr_master_model.w(5);
        t_addr(40'h80a5017ffe);
        t_freeze(40'h5a0f10e7c3);
        t_hold(40'h5a0f10e7c3);
        conclude();
    end
endmodule : dlr_i2c_slave_tb
